//--- rtl/csm_pkg.sv
// csm_pkg: constants and types of the capacitive-sense channel select and activity monitor
package csm_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] CSM_IDX_CHAN_SEL = 10'h0ab;
	localparam logic [9:0] CSM_IDX_MONITOR  = 10'h0de;
	localparam logic [9:0] CSM_IDX_STATUS   = 10'h0df;
	localparam int         CSM_ADDR_W       = 12;
	localparam logic [CSM_ADDR_W-1:0] CSM_ADDR_CHAN_SEL = {CSM_IDX_CHAN_SEL, 2'b00};
	localparam logic [CSM_ADDR_W-1:0] CSM_ADDR_MONITOR  = {CSM_IDX_MONITOR, 2'b00};
	localparam logic [CSM_ADDR_W-1:0] CSM_ADDR_STATUS   = {CSM_IDX_STATUS, 2'b00};

	// reset values
	localparam logic [7:0] CSM_CHAN_SEL_RST = 8'h00;
	localparam logic [7:0] CSM_MONITOR_RST  = 8'h00;

	// monitor register field positions
	localparam int CSM_BIT_UART = 7;
	localparam int CSM_BIT_SPI  = 6;
	localparam int CSM_BIT_SMB  = 5;
	localparam int CSM_BIT_PCA  = 4;
	localparam int CSM_BIT_PIO  = 3;
	localparam int CSM_BIT_CMP  = 2;
	localparam int CSM_MODE_HI  = 1;
	localparam int CSM_MODE_LO  = 0;

	// channel field and decode limits
	localparam int         CSM_CHAN_W    = 4;
	localparam logic [3:0] CSM_CHAN_LAST = 4'hd;

	// status register field positions
	localparam int CSM_ST_EVENT   = 0;
	localparam int CSM_ST_CNT_LO  = 1;
	localparam int CSM_ST_CNT_HI  = 3;
	localparam int CSM_ST_CONV    = 4;

	// consecutive retry limits
	localparam logic [2:0] CSM_LIMIT_TWO  = 3'h2;
	localparam logic [2:0] CSM_LIMIT_FOUR = 3'h4;

	// axi responses
	localparam logic [1:0] CSM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CSM_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CSM_RETRY_ALL,
		CSM_RETRY_TWO,
		CSM_RETRY_FOUR,
		CSM_RETRY_RSVD
	} csm_mode_t;

	// watched peripheral pins
	typedef struct packed {
		logic       uart_tx;
		logic [2:0] spi_out;
		logic [1:0] smb;
		logic [2:0] pca_out;
		logic       cmp_out;
	} csm_watch_t;

	localparam int CSM_WATCH_W = $bits(csm_watch_t);

endpackage

//--- rtl/csm_change_det.sv
// csm_change_det: two-stage pin synchroniser and per-pin change detector
`timescale 1ns/1ps
module csm_change_det #(
	parameter int W = 10
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         clk_en,
	// pins and change flags
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] changed
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	if (W < 1)
		$error("csm_change_det needs at least one pin");

	// first stage feeds only the second stage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else if (clk_en)
		begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	// history after the synchroniser; reset state matches so no false edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prev_q <= '0;
		else if (clk_en)
			prev_q <= sync_q;
	end

	assign changed = sync_q ^ prev_q;

endmodule

//--- rtl/csm_monitor_top.sv
// csm_monitor_top: sense channel select and activity monitor with an axi4-lite register slave
`timescale 1ns/1ps
// Behaviour
// - Bit 6 enables watching the sync serial output pins during conversion.
// - Bit 5 enables watching the two-wire bus pins during conversion.
// - Bit 4 enables watching the counter array output pins during conversion.
// - Bit 3 makes any port output latch write during conversion a monitored event.
// - Bit 2 enables watching comparator zero output transitions during conversion.
// - Channel selection comes from firmware writes or from the scan hardware.
// - Firmware writes change the routed channel at once, scan on or off, but a scan load in the same cycle wins.
// - With scanning enabled, scan hardware updates the selection register itself.
// - Codes 0-7 select port 0 pins, 8-13 port 1 pins; 14,15 reserved.
module csm_monitor_top
	import csm_pkg::*;
(
	// clock, reset, enable
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  clk_en,
	// axi4-lite write address
	input  wire logic [CSM_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read
	input  wire logic [CSM_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// scan sequencer
	input  wire logic                  scan_en,
	input  wire logic                  scan_load,
	input  wire logic [CSM_CHAN_W-1:0] scan_chan,
	// converter
	input  wire logic                  conv_active,
	input  wire logic                  bit_cycle_end,
	// monitored activity
	input  wire csm_watch_t            watch_pins,
	input  wire logic                  port_latch_wr,
	// analog mux and retry request
	output logic [CSM_CHAN_W-1:0]      sense_chan,
	output logic                       sense_chan_valid,
	output logic                       bit_retry
);

	// true for the fourteen implemented channel codes
	function automatic logic chan_ok(input logic [CSM_CHAN_W-1:0] c);
		chan_ok = (c <= CSM_CHAN_LAST);
	endfunction

	// true where an address maps to a register
	function automatic logic addr_ok(input logic [CSM_ADDR_W-1:0] a);
		addr_ok = (a == CSM_ADDR_CHAN_SEL) || (a == CSM_ADDR_MONITOR) || (a == CSM_ADDR_STATUS);
	endfunction

	logic [CSM_ADDR_W-1:0] awaddr_q;
	logic [31:0]           wdata_q;
	logic [3:0]            wstrb_q;
	logic                  wr_go;
	logic                  wr_chan;
	logic                  wr_mon;
	logic                  wr_stat;
	logic [7:0]            chan_reg_q;
	logic [7:0]            mon_q;
	logic                  event_q;
	logic                  bit_evt_q;
	logic [2:0]            cnt_q;
	logic [2:0]            cnt_d;
	logic                  retry_d;
	logic [CSM_WATCH_W-1:0] changed;
	csm_watch_t            chg;
	logic                  pin_evt;
	logic                  mon_evt;
	logic                  hit;
	logic [2:0]            limit;
	csm_mode_t             mode;
	logic [7:0]            status;

	// pin activity, synchronised inside
	csm_change_det #(
		.W (CSM_WATCH_W)
	) u_det (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clk_en  (clk_en),
		.pins    (watch_pins),
		.changed (changed)
	);

	assign chg = changed;

	// write address channel; held until the response is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			awaddr_q      <= '0;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				awaddr_q      <= s_axi_awaddr;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_awready <= 1'b1;
		end
	end

	// write data channel; taken independently of the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b1;
			wdata_q      <= '0;
			wstrb_q      <= '0;
		end
		else if (clk_en)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_wready <= 1'b1;
		end
	end

	// both halves held and no response pending: commit once
	assign wr_go   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_chan = wr_go && wstrb_q[0] && (awaddr_q == CSM_ADDR_CHAN_SEL);
	assign wr_mon  = wr_go && wstrb_q[0] && (awaddr_q == CSM_ADDR_MONITOR);
	assign wr_stat = wr_go && wstrb_q[0] && (awaddr_q == CSM_ADDR_STATUS);

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CSM_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(awaddr_q) ? CSM_RESP_OKAY : CSM_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// channel select: upper bits reserved and kept at zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			chan_reg_q <= CSM_CHAN_SEL_RST;
		else if (clk_en)
		begin
			if (scan_en && scan_load)
				chan_reg_q <= {4'h0, scan_chan};
			else if (wr_chan)
				chan_reg_q <= {4'h0, wdata_q[CSM_CHAN_W-1:0]};
		end
	end

	// routed channel follows the register one cycle later
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sense_chan       <= CSM_CHAN_SEL_RST[CSM_CHAN_W-1:0];
			sense_chan_valid <= 1'b1;
		end
		else if (clk_en)
		begin
			sense_chan       <= chan_reg_q[CSM_CHAN_W-1:0];
			sense_chan_valid <= chan_ok(chan_reg_q[CSM_CHAN_W-1:0]);
		end
	end

	// monitor enables and retry mode, all software owned
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mon_q <= CSM_MONITOR_RST;
		else if (clk_en && wr_mon)
			mon_q <= wdata_q[7:0];
	end

	assign mode = csm_mode_t'(mon_q[CSM_MODE_HI:CSM_MODE_LO]);

	// gate each watched group by its enable
	always_comb
	begin
		pin_evt = 1'b0;
		pin_evt = pin_evt | (mon_q[CSM_BIT_UART] & chg.uart_tx);
		pin_evt = pin_evt | (mon_q[CSM_BIT_SPI] & (|chg.spi_out));
		pin_evt = pin_evt | (mon_q[CSM_BIT_SMB] & (|chg.smb));
		pin_evt = pin_evt | (mon_q[CSM_BIT_PCA] & (|chg.pca_out));
		pin_evt = pin_evt | (mon_q[CSM_BIT_PIO] & port_latch_wr);
		pin_evt = pin_evt | (mon_q[CSM_BIT_CMP] & chg.cmp_out);
	end

	// only activity inside a conversion counts
	assign mon_evt = conv_active && pin_evt;
	assign hit     = bit_evt_q || mon_evt;

	// event seen in the current bit cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bit_evt_q <= 1'b0;
		else if (clk_en)
		begin
			if (!conv_active || bit_cycle_end)
				bit_evt_q <= 1'b0;
			else if (mon_evt)
				bit_evt_q <= 1'b1;
		end
	end

	// consecutive retry limit per mode
	always_comb
	begin
		limit = CSM_LIMIT_TWO;
		unique case (mode)
			CSM_RETRY_ALL:  limit = CSM_LIMIT_FOUR;
			CSM_RETRY_TWO:  limit = CSM_LIMIT_TWO;
			CSM_RETRY_FOUR: limit = CSM_LIMIT_FOUR;
			CSM_RETRY_RSVD: limit = CSM_LIMIT_TWO;
		endcase
	end

	// retry decision at the end of each bit cycle
	always_comb
	begin
		retry_d = 1'b0;
		cnt_d   = cnt_q;
		if (!conv_active)
			cnt_d = '0;
		else if (bit_cycle_end)
		begin
			if (!hit)
				cnt_d = '0;
			else if (mode == CSM_RETRY_ALL)
				retry_d = 1'b1;
			else if (mode != CSM_RETRY_RSVD && cnt_q < limit)
			begin
				retry_d = 1'b1;
				cnt_d   = cnt_q + 3'h1;
			end
			else
				cnt_d = '0; // limit reached or reserved mode: accept the bit and rearm
		end
	end

	// retry pulse and run length
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_retry <= 1'b0;
			cnt_q     <= '0;
		end
		else if (clk_en)
		begin
			bit_retry <= retry_d;
			cnt_q     <= cnt_d;
		end
	end

	// sticky event flag; a new event beats a software clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			event_q <= 1'b0;
		else if (clk_en)
		begin
			if (mon_evt)
				event_q <= 1'b1;
			else if (wr_stat && wdata_q[CSM_ST_EVENT])
				event_q <= 1'b0;
		end
	end

	// status view of the block's own state
	always_comb
	begin
		status                            = '0;
		status[CSM_ST_EVENT]              = event_q;
		status[CSM_ST_CNT_HI:CSM_ST_CNT_LO] = cnt_q;
		status[CSM_ST_CONV]               = conv_active;
	end

	// read channel; data picked at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= CSM_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= addr_ok(s_axi_araddr) ? CSM_RESP_OKAY : CSM_RESP_SLVERR;
				unique case (s_axi_araddr)
					CSM_ADDR_CHAN_SEL: s_axi_rdata <= {24'h0, chan_reg_q};
					CSM_ADDR_MONITOR:  s_axi_rdata <= {24'h0, mon_q};
					CSM_ADDR_STATUS:   s_axi_rdata <= {24'h0, status};
					default:           s_axi_rdata <= '0;
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

//--- sim/csm_monitor_top_assertions.sv
// csm_monitor_top_assertions: port-level timing checks of the channel select and monitor block
`timescale 1ns/1ps
module csm_monitor_top_assertions
	import csm_pkg::*;
(
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       clk_en,
	// register bus handshakes
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	// scan, converter and mux
	input wire logic       scan_en,
	input wire logic       scan_load,
	input wire logic [3:0] scan_chan,
	input wire logic       bit_cycle_end,
	input wire logic       bit_retry,
	input wire logic [3:0] sense_chan,
	input wire logic       sense_chan_valid
);
	// one clock domain, so one default clock and reset for all
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_chan_decode; sense_chan_valid == (sense_chan <= CSM_CHAN_LAST); endproperty
	a_chan_decode: assert property (p_chan_decode) else $error("channel valid flag wrong");
	property p_scan_load; clk_en && scan_en && scan_load |-> ##2 sense_chan == $past(scan_chan, 2); endproperty
	a_scan_load: assert property (p_scan_load) else $error("scan load not routed");
	property p_retry_cause; bit_retry |-> $past(bit_cycle_end); endproperty
	a_retry_cause: assert property (p_retry_cause) else $error("retry without bit cycle end");
	// the write commits one edge after the take, the answer shows one edge later
	property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##1 !s_axi_bvalid ##1 s_axi_bvalid; endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer late");
	property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("second write taken early");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("second read taken early");
	// a low enable must hold the routed channel and the retry pulse as they were
	property p_freeze; !clk_en |=> $stable(sense_chan) && $stable(bit_retry); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");
	c_freeze: cover property (!clk_en && scan_load);
	c_retry: cover property (bit_retry);
	c_scan: cover property (scan_en && scan_load);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind csm_monitor_top csm_monitor_top_assertions csm_monitor_top_assertions_inst (.aclk(aclk), .aresetn(aresetn),
	.clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .scan_en(scan_en), .scan_load(scan_load), .scan_chan(scan_chan),
	.bit_cycle_end(bit_cycle_end), .bit_retry(bit_retry), .sense_chan(sense_chan),
	.sense_chan_valid(sense_chan_valid));

//--- sim/csm_monitor_top_bench.sv
// csm_monitor_top_bench: self-checking bench for the channel select and activity monitor
`timescale 1ns/1ps
module csm_monitor_top_bench;
	import csm_pkg::*;
	logic        aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
	logic        rready, scan_en, scan_load, conv_active, bit_cycle_end, port_latch_wr, chan_valid, bit_retry, g;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, scan_chan, sense_chan;
	logic [1:0]  bresp, rresp, r;
	csm_watch_t  watch;
	int          bad_count, checks_done, c, s, m, k, n, e;
	int          exp_q[$];

	csm_monitor_top csm_monitor_top_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scan_en(scan_en), .scan_load(scan_load), .scan_chan(scan_chan),
		.conv_active(conv_active), .bit_cycle_end(bit_cycle_end), .watch_pins(watch),
		.port_latch_wr(port_latch_wr), .sense_chan(sense_chan), .sense_chan_valid(chan_valid),
		.bit_retry(bit_retry));

	// 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// each channel is released on its own ready; a missing answer ends the run
	task automatic wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] resp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dat;
		{awvalid, wvalid, bready} <= 3'h7;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				resp = bresp;
				bready <= 1'b0;
				return;
			end
		end
		bad_count++;
		tally_and_finish;
	endtask

	task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] eresp);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rready <= 1'b0;
				check(rdata, exp);
				check(rresp, eresp);
				return;
			end
		end
		bad_count++;
		tally_and_finish;
	endtask

	// one bit cycle: event from source src (6 = none), then the end pulse; returns the retry flag
	task automatic bit_cyc(input int src, output logic got);
		@(posedge aclk);
		case (src)
			0: watch.uart_tx <= ~watch.uart_tx;
			1: watch.spi_out[0] <= ~watch.spi_out[0];
			2: watch.smb[0] <= ~watch.smb[0];
			3: watch.pca_out[0] <= ~watch.pca_out[0];
			4: port_latch_wr <= 1'b1;
			5: watch.cmp_out <= ~watch.cmp_out;
			default: ;
		endcase
		@(posedge aclk);
		port_latch_wr <= 1'b0;
		repeat (4) @(posedge aclk);
		bit_cycle_end <= 1'b1;
		@(posedge aclk);
		bit_cycle_end <= 1'b0;
		// the pulse stands until the next edge; take it there
		@(posedge aclk);
		got = bit_retry;
	endtask

	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, scan_en, scan_load, conv_active} = '0;
		{bit_cycle_end, port_latch_wr, aresetn} = '0;
		{awaddr, araddr, wdata, scan_chan} = '0;
		clk_en = 1'b1;
		wstrb = 4'hf;
		watch = '0;
		bad_count = 0;
		checks_done = 0;
		d = $urandom(21);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk_reg(CSM_ADDR_CHAN_SEL, 32'h0, CSM_RESP_OKAY);
		chk_reg(CSM_ADDR_MONITOR, 32'h0, CSM_RESP_OKAY);
		// every code routes at once; random upper bits must not stick
		for (c = 0; c < 16; c++)
		begin
			wr(CSM_ADDR_CHAN_SEL, ($urandom() & 32'hfffffff0) | c, r);
			check(r, CSM_RESP_OKAY);
			repeat (2) @(posedge aclk);
			check(sense_chan, c);
			check(chan_valid, c <= CSM_CHAN_LAST);
			chk_reg(CSM_ADDR_CHAN_SEL, c, CSM_RESP_OKAY);
		end
		chk_reg(12'h004, 32'h0, CSM_RESP_SLVERR);
		wr(12'h004, 32'hff, r);
		check(r, CSM_RESP_SLVERR);
		// scan hardware loads random codes, then firmware overrides with scan still on
		for (c = 0; c < 4; c++)
		begin
			e = $urandom_range(13);
			@(posedge aclk);
			scan_en <= 1'b1;
			scan_chan <= e[3:0];
			scan_load <= 1'b1;
			@(posedge aclk);
			scan_load <= 1'b0;
			repeat (2) @(posedge aclk);
			check(sense_chan, e);
			chk_reg(CSM_ADDR_CHAN_SEL, e, CSM_RESP_OKAY);
		end
		// a low enable freezes the register, a scan load included
		@(posedge aclk);
		clk_en <= 1'b0;
		scan_chan <= ~e[3:0];
		scan_load <= 1'b1;
		repeat (3) @(posedge aclk);
		check(sense_chan, e);
		clk_en <= 1'b1;
		scan_load <= 1'b0;
		chk_reg(CSM_ADDR_CHAN_SEL, e, CSM_RESP_OKAY);
		wr(CSM_ADDR_CHAN_SEL, 32'h5, r);
		repeat (2) @(posedge aclk);
		check(sense_chan, 4'h5);
		// each enable catches its own source and not the next one
		conv_active <= 1'b1;
		for (s = 0; s < 6; s++)
		begin
			wr(CSM_ADDR_MONITOR, 32'h1 << (7 - s), r);
			bit_cyc(s, g);
			check(g, 1'b1);
			bit_cyc((s + 1) % 6, g);
			check(g, 1'b0);
		end
		conv_active <= 1'b0;
		wr(CSM_ADDR_MONITOR, 32'hfc, r);
		bit_cyc(4, g);
		check(g, 1'b0);
		conv_active <= 1'b1;
		// retry modes against a counting model queued ahead, one quiet bit cycle, then an event in each of six
		for (m = 0; m < 4; m++)
		begin
			wr(CSM_ADDR_MONITOR, 32'h40 | m, r);
			bit_cyc(6, g);
			check(g, 1'b0);
			n = 0;
			for (k = 0; k < 6; k++)
			begin
				e = (m == 0) || (m != 3 && n < ((m == 1) ? 2 : 4));
				n = (m != 0 && e) ? n + 1 : 0;
				exp_q.push_back(e);
			end
			repeat (6)
			begin
				bit_cyc(1, g);
				check(g, exp_q.pop_front());
			end
			// sticky event, run length and conversion flag as the model has them
			chk_reg(CSM_ADDR_STATUS, (32'h1 << CSM_ST_EVENT) | (n << CSM_ST_CNT_LO) | (32'h1 << CSM_ST_CONV),
				CSM_RESP_OKAY);
		end
		// writing one to the event bit clears it when no new event competes
		wr(CSM_ADDR_STATUS, 32'h1 << CSM_ST_EVENT, r);
		check(r, CSM_RESP_OKAY);
		chk_reg(CSM_ADDR_STATUS, 32'h1 << CSM_ST_CONV, CSM_RESP_OKAY);
		tally_and_finish;
	end
endmodule
